// ---- core/device_bus_fail_status.sv ----
// device information and bus communication status registers with serial read and clear
`timescale 1ns/10ps
module device_bus_fail_status
(
   input wire logic i_core_clk,                           // core clock, 50 MHz
   input wire logic i_reset_n,                            // power-on reset, active low
   input wire logic i_clk_en,                             // clock enable, freezes all state except reset release
   input wire logic i_soft_reset,                         // soft reset command pulse
   input wire logic [2:0] i_config,                       // configuration selection
   input wire logic i_cmd_valid,                          // serial command strobe
   input wire status_pkg::serial_cmd_s i_cmd,             // serial command word
   input wire status_pkg::status_events_s i_events,       // event inputs
   output logic o_rdata_valid,                            // read answer strobe
   output logic [7:0] o_rdata,                            // register value read
   output logic o_fault_output,                           // fault output activation pulse
   output logic o_force_restart,                          // restart request pulse
   output logic o_can_tx_disable                          // can transmitter disable
);
   import status_pkg::*;

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // watchdog miss counter
   // ----------------------------------------------------------------
   logic [1:0] miss_count;
   logic miss_fire;

   watchdog_miss_counter u_miss
   (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_clk_en(i_clk_en),
      .i_soft_reset(i_soft_reset),
      .i_config(i_config),
      .i_miss(i_events.watchdog_miss),
      .i_good_trigger(i_events.watchdog_good_trigger),
      .i_stop(i_events.watchdog_stop),
      .i_stop_due_to_miss(i_events.stop_due_to_miss),
      .o_count(miss_count),
      .o_fault_fire(miss_fire),
      .o_force_restart(o_force_restart)
   );

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   logic [1:0] prev_state;
   logic bad_command;
   logic failure;
   logic [1:0] lin1_fault_code;
   logic [1:0] can_fault_code;
   logic can_supply_low_flag;

   wire hit_dev = i_cmd.addr == DEVICE_INFO_STATUS_ADDR;
   wire hit_bus = i_cmd.addr == BUS_COMM_STATUS_ONE_ADDR;
   wire clear_dev = i_cmd_valid && i_cmd.clear && hit_dev;
   wire clear_bus = i_cmd_valid && i_cmd.clear && hit_bus;
   wire read_hit = i_cmd_valid && (hit_dev || hit_bus);

   device_info_s dev_view;
   bus_comm_s bus_view;

   assign dev_view = '{previous_state_field: prev_state, reserved_hi: 2'h0,
                       watchdog_miss_count: miss_count, bad_command: bad_command,
                       failure: failure};
   assign bus_view = '{reserved_top: 1'b0, lin1_fault_code: lin1_fault_code,
                       reserved_mid: 2'h0, can_fault_code: can_fault_code,
                       can_supply_low_flag: can_supply_low_flag};

   // ----------------------------------------------------------------
   // next values, set wins over clear
   // ----------------------------------------------------------------
   wire fail_evt = i_events.restart_from_failure || i_events.fail_safe_wake
                   || i_events.illegal_stop_to_sleep || i_events.sleep_no_wake_source;
   wire sleep_evt = i_events.sleep_exit || i_events.sleep_with_wake_flags;
   wire supply_evt = i_events.can_supply_under && i_events.can_mode_high;

   wire [1:0] next_prev_state = fail_evt ? PREV_FAILURE :
                                sleep_evt ? PREV_SLEEP :
                                clear_dev ? PREV_CLEARED : prev_state;
   wire next_bad_command = i_events.invalid_command || (bad_command && !clear_dev);
   wire next_failure = miss_fire || (failure && !clear_dev);
   wire [1:0] next_lin1 = (i_events.lin1_fault != 2'h0) ? i_events.lin1_fault :
                          clear_bus ? 2'h0 : lin1_fault_code;
   wire [1:0] next_can = (i_events.can_fault != 2'h0) ? i_events.can_fault :
                         clear_bus ? 2'h0 : can_fault_code;
   wire next_supply_low = supply_evt || (can_supply_low_flag && !clear_bus);

   // ----------------------------------------------------------------
   // status storage
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_state <= STATUS_RESET[7:6];
         bad_command <= 1'b0;
         failure <= 1'b0;
         lin1_fault_code <= 2'h0;
         can_fault_code <= 2'h0;
         can_supply_low_flag <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (i_soft_reset)
         begin
            prev_state <= STATUS_RESET[7:6];
            bad_command <= 1'b0;
            failure <= 1'b0;
            lin1_fault_code <= 2'h0;
            can_fault_code <= 2'h0;
            can_supply_low_flag <= 1'b0;
         end
         else
         begin
            // restart entry touches no bus register bit: its other bits are always zero
            prev_state <= next_prev_state;
            bad_command <= next_bad_command;
            failure <= next_failure;
            lin1_fault_code <= next_lin1;
            can_fault_code <= next_can;
            can_supply_low_flag <= next_supply_low;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   wire [7:0] read_mux = hit_dev ? dev_view : bus_view;

   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         o_rdata_valid <= 1'b0;
         o_rdata <= STATUS_RESET;
         o_fault_output <= 1'b0;
         o_can_tx_disable <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_rdata_valid <= read_hit;
         o_rdata <= read_hit ? read_mux : o_rdata;
         o_fault_output <= miss_fire;
         o_can_tx_disable <= supply_evt;
      end
   end
endmodule

// ---- core/status_pkg.sv ----
// constants, field layouts and carrier types for the device and bus status registers
// Overview of operation
// - previous-state field 7:6: 00 cleared, 01 failure restart or fail-safe wake, 10 sleep
// - illegal stop-to-sleep or sleep without wake source also records failure code 01
// - sleep attempt with uncleared wake flags records sleep code 10
// - watchdog miss count 3:2: 01 one miss in configs 2 and 4, 10 two misses otherwise
// - miss count self-clears on good trigger or watchdog stop, unless stopped by miss
// - configs 2 and 4 freeze miss count after first counted miss until the count self-clears
// - config 0 first miss forces restart only, no fault output, no failure flag
// - bad-command flag bit 1 set on invalid serial command, cleared only by clear command or a reset
// - failure flag bit 0 set on fault output activation, held until host clears
// - reserved bits 5:4 of device register, 7 and 4:3 of bus register read zero
// - can supply undervoltage sets bit 0 flag and disables can transmitter
// - can supply comparator active only while can mode high bit is one
// - power-on or soft reset loads zeros into both registers
// - restart entry keeps lin1, can fault and supply-low bits, zeros the rest
package status_pkg;
   // ----------------------------------------------------------------
   // register addresses and reset values
   // ----------------------------------------------------------------
   localparam logic [6:0] DEVICE_INFO_STATUS_ADDR = 7'h43;
   localparam logic [6:0] BUS_COMM_STATUS_ONE_ADDR = 7'h44;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int CMD_ACCESS_BIT = 7;

   // ----------------------------------------------------------------
   // field codes
   // ----------------------------------------------------------------
   localparam logic [1:0] PREV_CLEARED = 2'h0;
   localparam logic [1:0] PREV_FAILURE = 2'h1;
   localparam logic [1:0] PREV_SLEEP = 2'h2;
   localparam logic [1:0] MISS_NONE = 2'h0;
   localparam logic [1:0] MISS_ONE = 2'h1;
   localparam logic [1:0] MISS_TWO = 2'h2;
   localparam logic [2:0] CFG_ZERO = 3'h0;
   localparam logic [2:0] CFG_TWO = 3'h2;
   localparam logic [2:0] CFG_FOUR = 3'h4;

   typedef struct packed {
      logic [1:0] previous_state_field;
      logic [1:0] reserved_hi;
      logic [1:0] watchdog_miss_count;
      logic bad_command;
      logic failure;
   } device_info_s;

   typedef struct packed {
      logic reserved_top;
      logic [1:0] lin1_fault_code;
      logic [1:0] reserved_mid;
      logic [1:0] can_fault_code;
      logic can_supply_low_flag;
   } bus_comm_s;

   // serial command as received: access bit, address, data byte
   typedef struct packed {
      logic clear;
      logic [6:0] addr;
      logic [7:0] data;
   } serial_cmd_s;

   // events reported by the surrounding mode, watchdog and transceiver logic
   typedef struct packed {
      logic restart_entry;
      logic restart_from_failure;
      logic fail_safe_wake;
      logic sleep_exit;
      logic illegal_stop_to_sleep;
      logic sleep_no_wake_source;
      logic sleep_with_wake_flags;
      logic watchdog_miss;
      logic watchdog_good_trigger;
      logic watchdog_stop;
      logic stop_due_to_miss;
      logic invalid_command;
      logic [1:0] lin1_fault;
      logic [1:0] can_fault;
      logic can_supply_under;
      logic can_mode_high;
   } status_events_s;
endpackage

// ---- core/watchdog_miss_counter.sv ----
// watchdog miss counter with self-clearing and freeze behaviour
`timescale 1ns/10ps
module watchdog_miss_counter
(
   input wire logic i_core_clk,              // core clock
   input wire logic i_rst_n,                 // synchronised reset, active low
   input wire logic i_clk_en,                // clock enable
   input wire logic i_soft_reset,            // soft reset pulse
   input wire logic [2:0] i_config,          // configuration selection
   input wire logic i_miss,                  // watchdog trigger failure
   input wire logic i_good_trigger,          // successful watchdog trigger
   input wire logic i_stop,                  // watchdog stopped
   input wire logic i_stop_due_to_miss,      // stop reached through a miss
   output logic [1:0] o_count,               // miss count
   output logic o_fault_fire,                // fault output activation pulse
   output logic o_force_restart              // restart request pulse
);
   import status_pkg::*;

   logic frozen;
   logic [1:0] next_count;
   logic next_frozen;
   logic next_fire;
   logic next_restart;

   wire freeze_cfg = (i_config == CFG_TWO) || (i_config == CFG_FOUR);
   wire single_cfg = (i_config == CFG_TWO);
   wire clear_req = i_good_trigger || (i_stop && !i_stop_due_to_miss);
   wire [1:0] limit = single_cfg ? MISS_ONE : MISS_TWO;
   wire count_req = i_miss && !frozen && (o_count != limit);
   wire [1:0] bumped = o_count + 2'h1;

   always_comb
   begin
      next_count = o_count;
      next_frozen = frozen;
      next_fire = 1'b0;
      next_restart = 1'b0;
      if (clear_req)
      begin
         next_count = MISS_NONE;
         next_frozen = 1'b0;
      end
      else if (count_req)
      begin
         next_count = bumped;
         next_frozen = freeze_cfg;
         next_restart = 1'b1;
         // config 0 first miss restarts only
         next_fire = (bumped == limit) && !((i_config == CFG_ZERO) && (bumped == MISS_ONE));
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_count <= MISS_NONE;
         frozen <= 1'b0;
         o_fault_fire <= 1'b0;
         o_force_restart <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_count <= i_soft_reset ? MISS_NONE : next_count;
         frozen <= i_soft_reset ? 1'b0 : next_frozen;
         o_fault_fire <= next_fire && !i_soft_reset;
         o_force_restart <= next_restart && !i_soft_reset;
      end
   end
endmodule

// ---- verif/device_bus_fail_status_props.sv ----
// port assertions for the status register block
`timescale 1ns/10ps
module device_bus_fail_status_props
(
   input wire logic i_core_clk,                     // clock
   input wire logic i_reset_n,                      // reset
   input wire logic i_clk_en,                       // enable
   input wire logic i_soft_reset,                   // soft reset
   input wire logic [2:0] i_config,                 // config
   input wire logic i_cmd_valid,                    // strobe
   input wire status_pkg::serial_cmd_s i_cmd,       // command
   input wire status_pkg::status_events_s i_events, // events
   input wire logic o_rdata_valid,                  // answer strobe
   input wire logic [7:0] o_rdata,                  // answer
   input wire logic o_fault_output,                 // fault pulse
   input wire logic o_force_restart,                // restart pulse
   input wire logic o_can_tx_disable                // tx off
);
   import status_pkg::*;
   wire hit_dev;
   wire hit_bus;
   wire hit;
   assign hit_dev = i_clk_en && i_cmd_valid && i_cmd.addr == DEVICE_INFO_STATUS_ADDR;
   assign hit_bus = i_clk_en && i_cmd_valid && i_cmd.addr == BUS_COMM_STATUS_ONE_ADDR;
   assign hit = hit_dev || hit_bus;
   default clocking dc @(posedge i_core_clk);
   endclocking
   default disable iff (!i_reset_n);
   AST_ANSWER: assert property (hit |=> o_rdata_valid) else $error("mapped command unanswered");
   AST_NO_ANSWER: assert property (!hit |=> !o_rdata_valid) else $error("answer without command");
   AST_DEV_RSV: assert property (o_rdata_valid && $past(hit_dev) |-> o_rdata[5:4] == 2'b00) else $error("dev rsv");
   AST_BUS_RSV: assert property (o_rdata_valid && $past(hit_bus) |-> {o_rdata[7], o_rdata[4:3]} == 3'h0)
      else $error("bus reserved bits set");
   AST_TX_OFF: assert property (i_clk_en && i_events.can_supply_under && i_events.can_mode_high |=> o_can_tx_disable)
      else $error("transmitter not disabled");
   AST_TX_ON: assert property (i_clk_en && !i_events.can_mode_high |=> !o_can_tx_disable) else $error("comparator on");
   AST_RESTART: assert property (o_force_restart |-> $past(i_events.watchdog_miss)) else $error("restart without miss");
   AST_FAULT: assert property (o_fault_output |-> $past(o_force_restart)) else $error("fault without counted miss");
   AST_SOFT: assert property ((i_clk_en && i_soft_reset) ##1 hit_bus |=> o_rdata == STATUS_RESET)
      else $error("soft reset left bits");
   AST_BAD_CMD: assert property ((i_clk_en && i_events.invalid_command) ##1 hit_dev |=> o_rdata[1])
      else $error("bad command flag not set");
endmodule

bind device_bus_fail_status device_bus_fail_status_props props_u
(
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_soft_reset(i_soft_reset),
   .i_config(i_config), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_events(i_events),
   .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata), .o_fault_output(o_fault_output),
   .o_force_restart(o_force_restart), .o_can_tx_disable(o_can_tx_disable)
);

// ---- verif/status_host_model.sv ----
// host side model forming serial read and clear commands
`timescale 1ns/10ps
module status_host_model
(
   input wire logic i_req,                   // send a command
   input wire logic i_clear,                 // clear instead of read
   input wire logic [6:0] i_addr,            // register address
   output logic o_cmd_valid,                 // command strobe
   output status_pkg::serial_cmd_s o_cmd     // command word
);
   import status_pkg::*;
   serial_cmd_s word;
   assign word = {i_clear, i_addr, 8'h00};
   // outside a command the word is inverted so no stale value looks valid
   assign o_cmd = i_req ? word : ~word;
   assign o_cmd_valid = i_req;
endmodule

// ---- verif/device_bus_fail_status_tb_top.sv ----
// self-checking bench for the status register block
`timescale 1ns/10ps
module device_bus_fail_status_tb_top;
   import status_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic i_soft_reset = 1'b0;
   logic [2:0] i_config = 3'h0;
   logic req = 1'b0;
   logic clr = 1'b0;
   logic [6:0] addr = 7'h00;
   logic cmd_valid;
   serial_cmd_s cmd;
   status_events_s ev = '0;
   logic rdata_valid;
   logic [7:0] rdata;
   logic fault;
   logic restart;
   logic tx_off;
   logic en = 1'b1;
   int n_fault = 0;
   int n_restart = 0;
   logic [7:0] v;
   logic saw;
   int fails = 0;
   int n_checks = 0;
   always #10 i_core_clk = ~i_core_clk;
   always @(posedge i_core_clk)
   begin
      if (fault === 1'b1) n_fault <= n_fault + 1;
      if (restart === 1'b1) n_restart <= n_restart + 1;
   end
   status_host_model host_u (.i_req(req), .i_clear(clr), .i_addr(addr), .o_cmd_valid(cmd_valid), .o_cmd(cmd));
   device_bus_fail_status dut_u
   (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(en), .i_soft_reset(i_soft_reset),
      .i_config(i_config), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_events(ev), .o_rdata_valid(rdata_valid),
      .o_rdata(rdata), .o_fault_output(fault), .o_force_restart(restart), .o_can_tx_disable(tx_off)
   );
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic fire();
      tick(1);
      ev = '0;
   endtask
   task automatic access(input logic c, input logic [6:0] a, output logic [7:0] val, output logic got);
      req = 1'b1;
      clr = c;
      addr = a;
      tick(1);
      req = 1'b0;
      for (int k = 0; k < 3 && rdata_valid !== 1'b1; k++) tick(1);
      got = (rdata_valid === 1'b1);
      val = rdata;
      // one idle edge so the next request never re-raises the strobe in this time step
      tick(1);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
      access(1'b0, a, v, saw);
      check({what, " answered"}, {7'h00, saw}, 8'h01);
      check(what, v, exp);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #(20 * 3000);
      fails++;
      conclude();
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      tick(10);
      i_reset_n = 1'b1;
      tick(3);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h00, "device reset");
      rd(BUS_COMM_STATUS_ONE_ADDR, 8'h00, "bus reset");
      ev.invalid_command = 1'b1;
      fire();
      rd(DEVICE_INFO_STATUS_ADDR, 8'h02, "bad command");
      access(1'b1, DEVICE_INFO_STATUS_ADDR, v, saw);
      check("clear returns", v, 8'h02);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h00, "after clear");
      en = 1'b0;
      ev.invalid_command = 1'b1;
      fire();
      en = 1'b1;
      rd(DEVICE_INFO_STATUS_ADDR, 8'h00, "enable low freezes");
      for (int k = 0; k < 6; k++)
      begin
         ev.restart_from_failure = (k == 0);
         ev.fail_safe_wake = (k == 1);
         ev.illegal_stop_to_sleep = (k == 2);
         ev.sleep_no_wake_source = (k == 3);
         ev.sleep_exit = (k == 4);
         ev.sleep_with_wake_flags = (k == 5);
         fire();
         access(1'b1, DEVICE_INFO_STATUS_ADDR, v, saw);
         check("previous state", v, (k < 4) ? 8'h40 : 8'h80);
      end
      i_config = CFG_TWO;
      ev.watchdog_miss = 1'b1;
      fire();
      tick(2);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h05, "one miss");
      check("fault fired", n_fault[7:0], 8'h01);
      ev.watchdog_miss = 1'b1;
      fire();
      tick(2);
      access(1'b1, DEVICE_INFO_STATUS_ADDR, v, saw);
      check("frozen count", v, 8'h05);
      check("restart frozen", n_restart[7:0], 8'h01);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h04, "count kept");
      ev.watchdog_good_trigger = 1'b1;
      fire();
      tick(1);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h00, "good trigger");
      i_config = CFG_ZERO;
      ev.watchdog_miss = 1'b1;
      fire();
      tick(2);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h04, "first miss");
      check("no fault", n_fault[7:0], 8'h01);
      check("restart only", n_restart[7:0], 8'h02);
      ev.watchdog_miss = 1'b1;
      fire();
      tick(2);
      rd(DEVICE_INFO_STATUS_ADDR, 8'h09, "second miss");
      ev.watchdog_stop = 1'b1;
      fire();
      tick(1);
      access(1'b1, DEVICE_INFO_STATUS_ADDR, v, saw);
      check("stop clears count", v, 8'h01);
      i_config = CFG_FOUR;
      for (int k = 0; k < 2; k++)
      begin
         ev.watchdog_miss = 1'b1;
         fire();
         tick(1);
      end
      rd(DEVICE_INFO_STATUS_ADDR, 8'h04, "config four frozen");
      ev.watchdog_good_trigger = 1'b1;
      fire();
      for (int k = 1; k < 4; k++)
      begin
         ev.lin1_fault = k[1:0];
         ev.can_fault = k[1:0];
         fire();
         access(1'b1, BUS_COMM_STATUS_ONE_ADDR, v, saw);
         check("fault codes", v, {1'b0, k[1:0], 2'b00, k[1:0], 1'b0});
      end
      ev.can_supply_under = 1'b1;
      tick(2);
      rd(BUS_COMM_STATUS_ONE_ADDR, 8'h00, "comparator off");
      ev.can_mode_high = 1'b1;
      ev.lin1_fault = 2'h3;
      tick(2);
      check("tx disable", {7'h00, tx_off}, 8'h01);
      ev.can_supply_under = 1'b0;
      ev.lin1_fault = 2'h0;
      ev.restart_entry = 1'b1;
      fire();
      rd(BUS_COMM_STATUS_ONE_ADDR, 8'h61, "restart keeps");
      access(1'b0, 7'h45, v, saw);
      check("unmapped answer", {7'h00, saw}, 8'h00);
      ev.invalid_command = 1'b1;
      fire();
      i_soft_reset = 1'b1;
      tick(1);
      i_soft_reset = 1'b0;
      rd(BUS_COMM_STATUS_ONE_ADDR, 8'h00, "soft reset bus");
      rd(DEVICE_INFO_STATUS_ADDR, 8'h00, "soft reset device");
      conclude();
   end
endmodule
